// file: qsla_defs.vh
`ifndef QSLA_DEFS_VH
`define QSLA_DEFS_VH
// Operation
// - each receive port picks CSI-2 or RAW input via two-bit mode field
// - mode strap can set the receive input mode instead of software
// - CSI-2 input mode decodes the forward link as 40-bit frames
// - each frame yields video payload, control bytes and diagnostics
// - RAW input mode decodes 28-bit frames at lower line rate
// - every output packet carries a virtual channel id in header
// - CSI-2 mode remaps incoming virtual channel ids per receive port
// - forwarding control maps any receive port onto the one output
// - synchronous mode: line 160x, pixel 4x, back channel 2x reference
// - non-synchronous mode needs back channel programmed to 10 Mbps
// - RAW 8/10/12 pixels become CSI-2 stream of same raw format
// - RAW mode inserts per-port programmable virtual channel and type
// - 12-bit HF RAW: 12 data plus 2 sync, 37.5 to 100 MHz
// - 12-bit LF RAW: 12 data plus 2 sync, 25 to 50 MHz
// - 10-bit RAW: 10 data plus 2 sync, 50 to 100 MHz
// - all RAW modes use a 2.5 Mbps back channel
// - YUV formats packed like raw 8/10/12 are handled identically
// - output supports up to four lanes at up to 1.6 Gbps each
// - image and non-image packets (sync, embedded) are both forwarded
// - control channel runs continuously, independent of video blanking
// - 010 in back channel rate select gives 10 Mbps; sync default 50

// register indices; byte address is four times the index
`define QSLA_IDX_FWD_ENABLE  8'h20
`define QSLA_IDX_CSI_CTL     8'h33
`define QSLA_IDX_PORT_SEL    8'h4c
`define QSLA_IDX_PORT_STATUS 8'h4d
`define QSLA_IDX_BC_RATE     8'h58
`define QSLA_IDX_PORT_SETUP  8'h6d
`define QSLA_IDX_PORT_INFO   8'h6e
`define QSLA_IDX_RAW_HEADER  8'h70
`define QSLA_IDX_VC_REMAP    8'h72

// input link mode field codes
`define QSLA_MODE_CSI2    2'h0
`define QSLA_MODE_RAW12LF 2'h1
`define QSLA_MODE_RAW12HF 2'h2
`define QSLA_MODE_RAW10   2'h3

`define QSLA_FRAME_CSI2 6'h28
`define QSLA_FRAME_RAW  6'h1c

// back channel rate select codes and bit times
`define QSLA_BC_2M5  3'h0
`define QSLA_BC_10M  3'h2
`define QSLA_BC_50M  3'h6
`define QSLA_BC_2M5_NS 400
`define QSLA_BC_10M_NS 100
`define QSLA_BC_50M_NS 20
`define QSLA_PCLK_NS   20

// reset values and lane rate maximum
`define QSLA_RST_RAW_HDR  8'h2c
`define QSLA_RST_VC_REMAP 8'he4
`define QSLA_RST_CSI_CTL  8'h13
`define QSLA_RATE_MAX     3'h4

`define QSLA_DT_FS   6'h00
`define QSLA_DT_FE   6'h01
`define QSLA_DT_SHORT 6'h10
`define QSLA_DT_RAW8 6'h2a
`define QSLA_DT_YUV8 6'h1e
`endif

// file: qsla_top.v
`timescale 1ns/100ps
`include "qsla_defs.vh"
module qsla_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [11:0] paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  rx_link_clk,
  input  wire [3:0]  rx_link_data,
  input  wire [3:0]  rx_link_frame,
  input  wire [2:0]  mode_strap,
  input  wire        bc_tx_valid,
  input  wire [1:0]  bc_tx_port,
  input  wire [7:0]  bc_tx_byte,
  output reg         bc_busy,
  output reg  [3:0]  bc_line,
  input  wire        out_ready,
  output reg         out_valid,
  output reg         out_sop,
  output reg         out_eop,
  output reg  [1:0]  out_port,
  output reg  [1:0]  out_vc,
  output reg  [5:0]  out_dt,
  output reg  [15:0] out_data,
  output reg  [1:0]  csi_lane_count,
  output reg  [2:0]  csi_lane_rate,
  output reg         i2c_fwd_valid,
  output reg  [1:0]  i2c_fwd_port,
  output reg  [7:0]  i2c_fwd_data
);

  localparam BC_CYC_2M5 = `QSLA_BC_2M5_NS / `QSLA_PCLK_NS;
  localparam BC_CYC_10M = `QSLA_BC_10M_NS / `QSLA_PCLK_NS;
  localparam BC_CYC_50M = `QSLA_BC_50M_NS / `QSLA_PCLK_NS;
  localparam [7:0] CSI_RST = `QSLA_RST_CSI_CTL;

  function reg_hit;
    input [7:0] i;
    begin
      case (i)
        `QSLA_IDX_FWD_ENABLE, `QSLA_IDX_CSI_CTL, `QSLA_IDX_PORT_SEL,
        `QSLA_IDX_PORT_STATUS, `QSLA_IDX_BC_RATE, `QSLA_IDX_PORT_SETUP,
        `QSLA_IDX_PORT_INFO, `QSLA_IDX_RAW_HEADER,
        `QSLA_IDX_VC_REMAP: reg_hit = 1'b1;
        default: reg_hit = 1'b0;
      endcase
    end
  endfunction

  // pixel width from mode and programmed type; yuv shares raw packing
  function [15:0] pix_mask;
    input [1:0] m;
    input [5:0] dt;
    begin
      if (dt == `QSLA_DT_RAW8 || dt == `QSLA_DT_YUV8)
        pix_mask = 16'h00ff;
      else if (m == `QSLA_MODE_RAW10)
        pix_mask = 16'h03ff;
      else
        pix_mask = 16'h0fff;
    end
  endfunction

  function [4:0] bc_cycles;
    input [2:0] sel;
    begin
      case (sel)
        `QSLA_BC_2M5: bc_cycles = BC_CYC_2M5[4:0];
        `QSLA_BC_10M: bc_cycles = BC_CYC_10M[4:0];
        default:      bc_cycles = BC_CYC_50M[4:0];
      endcase
    end
  endfunction

  // configuration
  reg [7:0]  pmode_v;
  reg [3:0]  psync;
  reg [31:0] raw_hdr;
  reg [31:0] vcmap;
  reg [3:0]  fwd_en;
  reg [1:0]  port_sel;
  reg [2:0]  bc_rate;
  reg [2:0]  strap_s1;
  reg [2:0]  strap_s2;
  reg [1:0]  strap_cnt;

  wire [7:0] idx     = paddr[9:2];
  wire       hit     = reg_hit(idx) & (paddr[1:0] == 2'h0) &
                       (paddr[11:10] == 2'h0);
  wire       wr_en   = psel & penable & pready & pwrite & hit;
  wire [3:0] sel_oh  = 4'h1 << port_sel;
  wire       st_wr   = wr_en & (idx == `QSLA_IDX_PORT_STATUS);
  wire [3:0] clr_perr = (st_wr & pwdata[1]) ? sel_oh : 4'h0;
  wire [3:0] clr_ovf  = (st_wr & pwdata[2]) ? sel_oh : 4'h0;

  // per-port results, flattened
  wire [3:0]  hv_w;
  wire [3:0]  hsop_w;
  wire [3:0]  heop_w;
  wire [7:0]  hvc_w;
  wire [23:0] hdt_w;
  wire [63:0] hdata_w;
  wire [3:0]  iv_w;
  wire [31:0] idata_w;
  wire [31:0] stat_w;
  reg  [3:0]  take;
  reg  [3:0]  i2c_take;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : port
      reg  [2:0]  s1;
      reg  [2:0]  s2;
      reg         lclk_d;
      reg  [39:0] sh;
      reg  [5:0]  cnt;
      reg  [39:0] frm;
      reg         fdone;
      reg         vs_p;
      reg         hs_p;
      reg         hv;
      reg         hsop;
      reg         heop;
      reg  [1:0]  hvc;
      reg  [5:0]  hdt;
      reg  [15:0] hdata;
      reg         iv;
      reg  [7:0]  idata;
      reg         lock;
      reg         perr;
      reg         ovf;
      reg  [3:0]  diag;
      reg         w_v;
      reg         w_sop;
      reg         w_eop;
      reg  [1:0]  w_vc;
      reg  [5:0]  w_dt;
      reg  [15:0] w_data;

      wire [1:0]  m     = pmode_v[2*g+1:2*g];
      wire        csi   = (m == `QSLA_MODE_CSI2);
      wire [5:0]  flen  = csi ? `QSLA_FRAME_CSI2 : `QSLA_FRAME_RAW;
      wire        rise  = s2[0] & ~lclk_d;
      wire        ok    = csi ? ~^frm : ~^frm[27:0];
      wire        good  = fdone & ok;
      wire        i2cv  = csi ? frm[39] : frm[27];
      wire [7:0]  i2cb  = csi ? frm[38:31] : frm[26:19];
      wire [1:0]  kind  = frm[30:29];
      wire        hs    = frm[18];
      wire        vs    = frm[17];
      wire        vs_ev = vs ^ vs_p;
      wire [7:0]  rmap  = vcmap[8*g+7:8*g];
      wire [7:0]  rhdr  = raw_hdr[8*g+7:8*g];

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1     <= 3'h0;
          s2     <= 3'h0;
          lclk_d <= 1'b0;
          sh     <= 40'h0;
          cnt    <= 6'h0;
          frm    <= 40'h0;
          fdone  <= 1'b0;
        end else begin
          s1     <= {rx_link_frame[g], rx_link_data[g], rx_link_clk[g]};
          s2     <= s1;
          lclk_d <= s2[0];
          fdone  <= 1'b0;
          if (!s2[2]) begin
            cnt <= 6'h0;
          end else if (rise) begin
            sh <= {sh[38:0], s2[1]};
            if (cnt == flen - 6'h1) begin
              frm   <= {sh[38:0], s2[1]};
              fdone <= 1'b1;
              cnt   <= 6'h0;
            end else begin
              cnt <= cnt + 6'h1;
            end
          end
        end
      end

      // frame decode into one output word
      always @* begin
        w_v    = 1'b0;
        w_sop  = 1'b0;
        w_eop  = 1'b0;
        w_vc   = 2'h0;
        w_dt   = 6'h0;
        w_data = 16'h0;
        if (good & fwd_en[g]) begin
          if (csi) begin
            w_v    = (kind != 2'h0);
            w_sop  = (kind == 2'h1);
            w_eop  = (kind == 2'h3) |
                     ((kind == 2'h1) & (frm[26:21] < `QSLA_DT_SHORT));
            w_vc   = rmap[2*frm[28:27]+:2];
            w_dt   = frm[26:21];
            w_data = frm[20:5];
          end else begin
            w_vc = rhdr[7:6];
            if (vs_ev) begin
              w_v   = 1'b1;
              w_sop = 1'b1;
              w_eop = 1'b1;
              w_dt  = vs ? `QSLA_DT_FS : `QSLA_DT_FE;
            end else begin
              w_v    = hs | hs_p;
              w_sop  = hs & ~hs_p;
              w_eop  = ~hs & hs_p;
              w_dt   = rhdr[5:0];
              w_data = hs ? ({4'h0, frm[16:5]} & pix_mask(m, rhdr[5:0]))
                          : 16'h0;
            end
          end
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          vs_p  <= 1'b0;
          hs_p  <= 1'b0;
          hv    <= 1'b0;
          hsop  <= 1'b0;
          heop  <= 1'b0;
          hvc   <= 2'h0;
          hdt   <= 6'h0;
          hdata <= 16'h0;
          iv    <= 1'b0;
          idata <= 8'h0;
          lock  <= 1'b0;
          perr  <= 1'b0;
          ovf   <= 1'b0;
          diag  <= 4'h0;
        end else begin
          if (fdone)
            lock <= ok;
          if (good) begin
            diag <= frm[4:1];
            if (!csi) begin
              vs_p <= vs;
              // a sync edge defers a coincident line edge one frame
              if (!vs_ev)
                hs_p <= hs;
            end
          end
          if (w_v) begin
            hv    <= 1'b1;
            hsop  <= w_sop;
            heop  <= w_eop;
            hvc   <= w_vc;
            hdt   <= w_dt;
            hdata <= w_data;
          end else if (take[g]) begin
            hv <= 1'b0;
          end
          if (good & i2cv) begin
            iv    <= 1'b1;
            idata <= i2cb;
          end else if (i2c_take[g]) begin
            iv <= 1'b0;
          end
          // set wins over a same-cycle clear
          if (fdone & ~ok)
            perr <= 1'b1;
          else if (clr_perr[g])
            perr <= 1'b0;
          if (w_v & hv & ~take[g])
            ovf <= 1'b1;
          else if (clr_ovf[g])
            ovf <= 1'b0;
        end
      end

      assign hv_w[g]              = hv;
      assign hsop_w[g]            = hsop;
      assign heop_w[g]            = heop;
      assign hvc_w[2*g+1:2*g]     = hvc;
      assign hdt_w[6*g+5:6*g]     = hdt;
      assign hdata_w[16*g+15:16*g] = hdata;
      assign iv_w[g]              = iv;
      assign idata_w[8*g+7:8*g]   = idata;
      assign stat_w[8*g+7:8*g]    = {diag, 1'b0, ovf, perr, lock};
    end
  endgenerate

  // packet arbitration
  reg        locked;
  reg [1:0]  owner;
  reg [1:0]  rr;
  reg [1:0]  sel;
  reg        sel_ok;
  reg [1:0]  j;
  integer    k;
  wire       out_free = ~out_valid | out_ready;

  always @* begin
    sel    = owner;
    sel_ok = 1'b0;
    j      = 2'h0;
    if (locked) begin
      sel_ok = hv_w[owner];
    end else begin
      for (k = 3; k >= 0; k = k - 1) begin
        j = rr + k[1:0];
        if (hv_w[j] & hsop_w[j]) begin
          sel    = j;
          sel_ok = 1'b1;
        end
      end
    end
    take = (out_free & sel_ok) ? (4'h1 << sel) : 4'h0;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked    <= 1'b0;
      owner     <= 2'h0;
      rr        <= 2'h0;
      out_valid <= 1'b0;
      out_sop   <= 1'b0;
      out_eop   <= 1'b0;
      out_port  <= 2'h0;
      out_vc    <= 2'h0;
      out_dt    <= 6'h0;
      out_data  <= 16'h0;
    end else if (out_free) begin
      out_valid <= sel_ok;
      if (sel_ok) begin
        out_sop  <= hsop_w[sel];
        out_eop  <= heop_w[sel];
        out_port <= sel;
        out_vc   <= hvc_w[2*sel+:2];
        out_dt   <= hdt_w[6*sel+:6];
        out_data <= hdata_w[16*sel+:16];
        owner    <= sel;
        locked   <= ~heop_w[sel];
        if (heop_w[sel])
          rr <= sel + 2'h1;
      end
    end
  end

  // control bytes: lowest port first, frames arrive far apart
  integer q;
  integer t;
  always @* begin
    i2c_take = 4'h0;
    for (q = 3; q >= 0; q = q - 1)
      if (iv_w[q])
        i2c_take = 4'h1 << q;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_fwd_valid <= 1'b0;
      i2c_fwd_port  <= 2'h0;
      i2c_fwd_data  <= 8'h0;
    end else begin
      i2c_fwd_valid <= 1'b0;
      for (t = 0; t < 4; t = t + 1)
        if (i2c_take[t]) begin
          i2c_fwd_valid <= 1'b1;
          i2c_fwd_port  <= t[1:0];
          i2c_fwd_data  <= idata_w[8*t+:8];
        end
    end
  end

  // back channel serializer: start bit, 8 data lsb first, stop bit
  reg [9:0] bc_sh;
  reg [3:0] bc_left;
  reg [4:0] bc_div;
  reg [1:0] bc_p;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_sh   <= 10'h3ff;
      bc_left <= 4'h0;
      bc_div  <= 5'h0;
      bc_p    <= 2'h0;
      bc_busy <= 1'b0;
      bc_line <= 4'hf;
    end else if (!bc_busy) begin
      bc_line <= 4'hf;
      if (bc_tx_valid) begin
        bc_busy <= 1'b1;
        bc_p    <= bc_tx_port;
        bc_sh   <= {1'b1, bc_tx_byte, 1'b0};
        bc_left <= 4'ha;
        bc_div  <= 5'h0;
      end
    end else if (bc_div != 5'h0) begin
      bc_div <= bc_div - 5'h1;
    end else if (bc_left == 4'h0) begin
      bc_busy <= 1'b0;
      bc_line <= 4'hf;
    end else begin
      bc_line       <= 4'hf;
      bc_line[bc_p] <= bc_sh[0];
      bc_sh         <= {1'b1, bc_sh[9:1]};
      bc_left       <= bc_left - 4'h1;
      bc_div        <= bc_cycles(bc_rate) - 5'h1;
    end
  end

  // register read mux
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0;
    case (idx)
      `QSLA_IDX_FWD_ENABLE:  rd_val[3:0] = fwd_en;
      `QSLA_IDX_CSI_CTL:     rd_val[4:0] = {csi_lane_rate, csi_lane_count};
      `QSLA_IDX_PORT_SEL:    rd_val[1:0] = port_sel;
      `QSLA_IDX_PORT_STATUS: rd_val[7:0] = stat_w[8*port_sel+:8];
      `QSLA_IDX_BC_RATE:     rd_val[2:0] = bc_rate;
      `QSLA_IDX_PORT_SETUP:
        rd_val[2:0] = {psync[port_sel], pmode_v[2*port_sel+:2]};
      `QSLA_IDX_PORT_INFO:
        rd_val[5:0] = (pmode_v[2*port_sel+:2] == `QSLA_MODE_CSI2) ?
                      `QSLA_FRAME_CSI2 : `QSLA_FRAME_RAW;
      `QSLA_IDX_RAW_HEADER:  rd_val[7:0] = raw_hdr[8*port_sel+:8];
      `QSLA_IDX_VC_REMAP:    rd_val[7:0] = vcmap[8*port_sel+:8];
      default:               rd_val = 32'h0;
    endcase
  end

  wire [1:0] strap_mode = strap_s2[1:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata         <= 32'h0;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      pmode_v        <= 8'h0;
      psync          <= 4'hf;
      raw_hdr        <= {4{`QSLA_RST_RAW_HDR}};
      vcmap          <= {4{`QSLA_RST_VC_REMAP}};
      fwd_en         <= 4'hf;
      port_sel       <= 2'h0;
      bc_rate        <= `QSLA_BC_50M;
      csi_lane_count <= CSI_RST[1:0];
      csi_lane_rate  <= CSI_RST[4:2];
      strap_s1       <= 3'h0;
      strap_s2       <= 3'h0;
      strap_cnt      <= 2'h0;
    end else begin
      strap_s1 <= mode_strap;
      strap_s2 <= strap_s1;
      pready   <= psel & ~penable;
      if (psel & ~penable) begin
        prdata  <= hit ? rd_val : 32'h0;
        pslverr <= ~hit;
      end
      if (strap_cnt != 2'h3)
        strap_cnt <= strap_cnt + 2'h1;
      // strap is caught once, on the third clock after release
      if (strap_cnt == 2'h2) begin
        pmode_v <= {4{strap_mode}};
        psync   <= {4{strap_s2[2]}};
        bc_rate <= (strap_mode != `QSLA_MODE_CSI2) ? `QSLA_BC_2M5
                                                   : `QSLA_BC_50M;
      end
      if (wr_en) begin
        case (idx)
          `QSLA_IDX_FWD_ENABLE: fwd_en <= pwdata[3:0];
          `QSLA_IDX_CSI_CTL: begin
            csi_lane_count <= pwdata[1:0];
            csi_lane_rate  <= (pwdata[4:2] > `QSLA_RATE_MAX) ?
                              `QSLA_RATE_MAX : pwdata[4:2];
          end
          `QSLA_IDX_PORT_SEL: port_sel <= pwdata[1:0];
          `QSLA_IDX_BC_RATE:  bc_rate  <= pwdata[2:0];
          `QSLA_IDX_PORT_SETUP: begin
            pmode_v[2*port_sel+:2] <= pwdata[1:0];
            psync[port_sel]        <= pwdata[2];
          end
          `QSLA_IDX_RAW_HEADER: raw_hdr[8*port_sel+:8] <= pwdata[7:0];
          `QSLA_IDX_VC_REMAP:   vcmap[8*port_sel+:8]   <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

endmodule

// file: qsla_monitor.sv
`timescale 1ns/100ps
module qsla_monitor (
  input logic        pclk,
  input logic        presetn,
  input logic [11:0] paddr,
  input logic        psel,
  input logic        penable,
  input logic        pready,
  input logic        pslverr,
  input logic        bc_tx_valid,
  input logic        bc_busy,
  input logic [3:0]  bc_line,
  input logic        out_ready,
  input logic        out_valid,
  input logic        out_sop,
  input logic        out_eop,
  input logic [1:0]  out_port,
  input logic [1:0]  out_vc,
  input logic [5:0]  out_dt,
  input logic [15:0] out_data,
  input logic [2:0]  csi_lane_rate
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       pkt_open;
  logic [1:0] owner;
  // the port that owns the output between sop and eop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_open <= 1'b0;
      owner    <= 2'h0;
    end else if (out_valid && out_ready) begin
      if (out_sop && !out_eop) begin
        pkt_open <= 1'b1;
        owner    <= out_port;
      end else if (out_eop) begin
        pkt_open <= 1'b0;
      end
    end
  end
  sequence s_setup; psel && !penable; endsequence
  sequence s_take; bc_tx_valid && !bc_busy; endsequence
  property p_zero_wait; s_setup |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_misalign; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
  endproperty
  property p_hold; out_valid && !out_ready |=> out_valid &&
    $stable({out_sop, out_eop, out_port, out_vc, out_dt, out_data});
  endproperty
  property p_short; out_valid && out_sop && out_dt < 6'h10 |-> out_eop;
  endproperty
  property p_no_split; out_valid && pkt_open |->
    !out_sop && out_port == owner; endproperty
  property p_bc_take; s_take |=> bc_busy ##[0:1] bc_line != 4'hf;
  endproperty
  property p_bc_idle; !bc_busy |-> bc_line == 4'hf; endproperty
  property p_rate_clamp; csi_lane_rate <= 3'h4; endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_misalign: assert property (p_misalign)
    else $error("misaligned access not refused");
  a_hold: assert property (p_hold)
    else $error("stalled word changed");
  a_short: assert property (p_short)
    else $error("short packet without eop");
  a_no_split: assert property (p_no_split)
    else $error("packet split by another port");
  a_bc_take: assert property (p_bc_take)
    else $error("back channel byte not started");
  a_bc_idle: assert property (p_bc_idle)
    else $error("back channel line not idle high");
  a_rate_clamp: assert property (p_rate_clamp)
    else $error("lane rate above maximum");
endmodule

bind qsla_top qsla_monitor u_mon (.pclk, .presetn, .paddr, .psel,
  .penable, .pready, .pslverr, .bc_tx_valid, .bc_busy, .bc_line,
  .out_ready, .out_valid, .out_sop, .out_eop, .out_port, .out_vc,
  .out_dt, .out_data, .csi_lane_rate);

// file: qsla_ser_model.sv
`timescale 1ns/100ps
module qsla_ser_model (
  output logic [3:0] link_clk,
  output logic [3:0] link_data,
  output logic [3:0] link_frame
);
  initial begin
    link_clk   = 4'h0;
    link_data  = 4'h0;
    link_frame = 4'h0;
  end
  // one frame per call, so syncs change at most once per frame
  task automatic send(input int p, input logic [39:0] f, input int n);
    #13;
    link_frame[p] = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      link_data[p] = f[i];
      #80 link_clk[p] = 1'b1;
      #80 link_clk[p] = 1'b0;
    end
    #80 link_frame[p] = 1'b0;
    // released line shows the inverse so a stale bit never looks valid
    link_data[p] = ~f[0];
  endtask
endmodule

// file: qsla_bench.sv
`timescale 1ns/100ps
`include "qsla_defs.vh"
module qsla_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  rx_link_clk, rx_link_data, rx_link_frame, bc_line;
  logic [2:0]  mode_strap, csi_lane_rate;
  logic        bc_tx_valid, bc_busy, out_ready, out_valid, out_sop;
  logic        out_eop, i2c_fwd_valid, er;
  logic [1:0]  bc_tx_port, out_port, out_vc, csi_lane_count, i2c_fwd_port;
  logic [7:0]  bc_tx_byte, i2c_fwd_data;
  logic [5:0]  out_dt;
  logic [15:0] out_data;
  logic [9:0]  i2c_seen;
  int          mismatches, num_checks, cycles;
  int          rates[3] = '{0, 2, 6};
  int          lows[3] = '{40, 10, 2};
  localparam logic [28:0] FULL = 29'h1fffffff;
  localparam logic [28:0] HDR  = 29'h1fff0000;

  qsla_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .rx_link_clk, .rx_link_data,
    .rx_link_frame, .mode_strap, .bc_tx_valid, .bc_tx_port, .bc_tx_byte,
    .bc_busy, .bc_line, .out_ready, .out_valid, .out_sop, .out_eop,
    .out_port, .out_vc, .out_dt, .out_data, .csi_lane_count,
    .csi_lane_rate, .i2c_fwd_valid, .i2c_fwd_port, .i2c_fwd_data);
  qsla_ser_model ser (.link_clk(rx_link_clk), .link_data(rx_link_data),
    .link_frame(rx_link_frame));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // pulse is one cycle wide, so latch it here
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (i2c_fwd_valid === 1'b1) i2c_seen <= {i2c_fwd_port, i2c_fwd_data};
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // idle cycle after each transfer keeps psel from two writes per step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask

  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
    chk(rd, e);
  endtask

  function automatic logic [39:0] cfr(input logic [1:0] kd,
    input logic [1:0] vc, input logic [5:0] dt, input logic [15:0] d);
    logic [39:0] f;
    f = {1'b1, 8'h5a, kd, vc, dt, d, 4'h0, 1'b0};
    f[0] = ^f[39:1];
    return f;
  endfunction

  function automatic logic [39:0] rfr(input logic hs, input logic vs,
    input logic [11:0] px);
    logic [39:0] f;
    f = {12'h0, 1'b0, 8'h00, hs, vs, px, 4'h0, 1'b0};
    f[0] = ^f[39:1];
    return f;
  endfunction

  function automatic logic [28:0] w(input logic s, input logic e,
    input logic [1:0] p, input logic [1:0] v, input logic [5:0] t,
    input logic [15:0] d);
    return {1'b1, s, e, p, v, t, d};
  endfunction

  task automatic send(input int p, input logic [39:0] f, input int n);
    ser.send(p, f, n);
    @(posedge pclk);
  endtask

  task automatic get(input logic [28:0] e, input logic [28:0] m);
    out_ready <= 1'b1;
    for (int k = 0; k < 64; k++) begin
      @(posedge pclk);
      if (out_valid === 1'b1) break;
    end
    chk({3'h0, {out_valid, out_sop, out_eop, out_port, out_vc, out_dt,
      out_data} & m}, {3'h0, e & m});
    out_ready <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic bc(input logic [1:0] p, input int e);
    int n;
    n = 0;
    bc_tx_valid <= 1'b1;
    bc_tx_port  <= p;
    bc_tx_byte  <= 8'hfe;
    for (int k = 0; k < 600; k++) begin
      @(posedge pclk);
      bc_tx_valid <= 1'b0;
      if (bc_line[p] === 1'b0) n++;
      if (k > 2 && bc_busy !== 1'b1) break;
    end
    chk(n, e);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {bc_tx_valid, bc_tx_port, bc_tx_byte, out_ready} = '0;
    {mismatches, num_checks, cycles, i2c_seen} = '0;
    mode_strap = 3'h4;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    rc(`QSLA_IDX_PORT_SETUP, 32'h4);
    rc(`QSLA_IDX_BC_RATE, 32'h6);
    rc(`QSLA_IDX_PORT_INFO, 32'd40);
    rc(`QSLA_IDX_RAW_HEADER, 32'h2c);
    rc(`QSLA_IDX_VC_REMAP, 32'he4);
    rc(`QSLA_IDX_CSI_CTL, 32'h13);
    wr(`QSLA_IDX_CSI_CTL, 32'h1d);
    rc(`QSLA_IDX_CSI_CTL, 32'h11);
    chk({29'h0, csi_lane_rate}, 32'h4);
    chk({30'h0, csi_lane_count}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, {2'b00, `QSLA_IDX_BC_RATE, 2'b10}, 32'h0);
    chk({31'h0, er}, 32'h1);
    rc(`QSLA_IDX_BC_RATE, 32'h6);
    for (int r = 0; r < 3; r++) begin
      wr(`QSLA_IDX_BC_RATE, rates[r]);
      bc(r[1:0], lows[r]);
    end
    // out_ready stays low while frames land, so words must hold
    wr(`QSLA_IDX_VC_REMAP, 32'h1b);
    send(0, cfr(2'd1, 2'd1, 6'h00, 16'h1234), 40);
    get(w(1, 1, 0, 2'd2, 6'h00, 16'h1234), FULL);
    chk({22'h0, i2c_seen}, 32'h05a);
    send(0, cfr(2'd1, 2'd0, 6'h2a, 16'h0001), 40);
    send(0, cfr(2'd3, 2'd0, 6'h2a, 16'hbeef), 40);
    get(w(1, 0, 0, 2'd3, 6'h2a, 16'h0001), FULL);
    get(w(0, 1, 0, 2'd3, 6'h2a, 16'hbeef), FULL);
    send(0, cfr(2'd1, 2'd1, 6'h00, 16'h0) ^ 40'h1, 40);
    repeat (20) @(posedge pclk);
    chk({31'h0, out_valid}, 32'h0);
    rc(`QSLA_IDX_PORT_STATUS, 32'h2);
    wr(`QSLA_IDX_PORT_STATUS, 32'h2);
    rc(`QSLA_IDX_PORT_STATUS, 32'h0);
    wr(`QSLA_IDX_FWD_ENABLE, 32'he);
    send(0, cfr(2'd1, 2'd1, 6'h00, 16'h0), 40);
    chk({31'h0, out_valid}, 32'h0);
    rc(`QSLA_IDX_PORT_STATUS, 32'h1);
    wr(`QSLA_IDX_PORT_SEL, 32'h1);
    wr(`QSLA_IDX_PORT_SETUP, {30'h0, `QSLA_MODE_RAW10});
    rc(`QSLA_IDX_PORT_INFO, 32'd28);
    wr(`QSLA_IDX_RAW_HEADER, 32'hab);
    send(1, rfr(1'b0, 1'b1, 12'h000), 28);
    get(w(1, 1, 1, 2'd2, 6'h00, 16'h0), HDR);
    send(1, rfr(1'b1, 1'b1, 12'hfff), 28);
    get(w(1, 0, 1, 2'd2, 6'h2b, 16'h03ff), FULL);
    send(1, rfr(1'b0, 1'b1, 12'h000), 28);
    get(w(0, 1, 1, 2'd2, 6'h2b, 16'h0000), FULL);
    wr(`QSLA_IDX_PORT_SETUP, {30'h0, `QSLA_MODE_RAW12LF});
    wr(`QSLA_IDX_RAW_HEADER, 32'h9e);
    send(1, rfr(1'b1, 1'b1, 12'hfff), 28);
    get(w(1, 0, 1, 2'd2, 6'h1e, 16'h00ff), FULL);
    wr(`QSLA_IDX_PORT_SETUP, {30'h0, `QSLA_MODE_RAW12HF});
    wr(`QSLA_IDX_RAW_HEADER, 32'hac);
    send(1, rfr(1'b1, 1'b1, 12'hfff), 28);
    get(w(0, 0, 1, 2'd2, 6'h2c, 16'h0fff), FULL);
    send(1, rfr(1'b0, 1'b1, 12'h000), 28);
    get(w(0, 1, 1, 2'd2, 6'h2c, 16'h0000), FULL);
    wr(`QSLA_IDX_PORT_SEL, 32'h0);
    rc(`QSLA_IDX_PORT_INFO, 32'd40);
    report_and_stop();
  end
endmodule
